/* File: hdl/stl_fault_lamp.v */
`timescale 1ns/1ps
`default_nettype none
module stl_fault_lamp (
  input wire mclk,
  input wire srst,
  input wire normal_mode,
  input wire exchange_start_req,
  input wire no_active_slave,
  input wire duplicate_address,
  output reg fault_lamp
);
  reg req_q;
  always @(posedge mclk) begin
    if (srst) begin
      req_q <= 1'h0;
      fault_lamp <= 1'h0;
    end else begin
      req_q <= exchange_start_req;
      if (!normal_mode) begin
        fault_lamp <= 1'h0;
      end else if (exchange_start_req && !req_q) begin
        // judged only on the rising request; held until the request drops or normal_mode goes low
        fault_lamp <= no_active_slave | duplicate_address;
      end else if (!exchange_start_req) begin
        fault_lamp <= 1'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/stl_map.vh */
`ifndef STL_MAP_VH
`define STL_MAP_VH
// rotary mode selector positions
`define STL_MODE_NORMAL 4'h0
`define STL_MODE_PARAM 4'h1
`define STL_MODE_TEST 4'h2
`define STL_MODE_EXT 4'hE
// lamp codes, bit 6 down to bit 0
`define STL_RUN_CPU 7'h03
`define STL_RUN_TMR 7'h05
`define STL_RUN_IRQ 7'h07
`define STL_RUN_MEM1 7'h0B
`define STL_RUN_MEM2 7'h0D
`define STL_ERR_CPU 7'h42
`define STL_ERR_TMR 7'h44
`define STL_ERR_IRQ 7'h46
`define STL_ERR_MEM 7'h4E
// phase encoding
`define STL_PH_CPU 3'h0
`define STL_PH_TMR 3'h1
`define STL_PH_IRQ 3'h2
`define STL_PH_MEM1 3'h3
`define STL_PH_MEM2 3'h4
`endif

/* File: hdl/stl_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "stl_map.vh"
module stl_sequencer (
  input wire mclk,
  input wire srst,
  input wire [3:0] mode_select,
  input wire test_done,
  input wire test_pass,
  input wire exchange_start_req,
  input wire no_active_slave,
  input wire duplicate_address,
  output reg [2:0] test_phase,
  output reg test_start,
  output reg test_lamp,
  output reg [6:0] station_number_lamps,
  output reg mode_normal,
  output reg mode_param,
  output reg mode_ext,
  output reg mode_unusable,
  output wire fault_lamp
);
  // wait covers a phase in progress; err is left only by turning the selector
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_ERR = 2'h3;

  function [6:0] run_code;
    input [2:0] ph;
    begin
      case (ph)
        `STL_PH_CPU: begin
          run_code = `STL_RUN_CPU;
        end
        `STL_PH_TMR: begin
          run_code = `STL_RUN_TMR;
        end
        `STL_PH_IRQ: begin
          run_code = `STL_RUN_IRQ;
        end
        `STL_PH_MEM1: begin
          run_code = `STL_RUN_MEM1;
        end
        `STL_PH_MEM2: begin
          run_code = `STL_RUN_MEM2;
        end
        default: begin
          // codes 5 to 7 never occur; dark lamps would read as a lamp fault
          run_code = `STL_RUN_MEM2;
        end
      endcase
    end
  endfunction

  function [6:0] err_code;
    input [2:0] ph;
    begin
      case (ph)
        `STL_PH_CPU: begin
          err_code = `STL_ERR_CPU;
        end
        `STL_PH_TMR: begin
          err_code = `STL_ERR_TMR;
        end
        `STL_PH_IRQ: begin
          err_code = `STL_ERR_IRQ;
        end
        default: begin
          // both memory phases share one error pattern
          err_code = `STL_ERR_MEM;
        end
      endcase
    end
  endfunction

  // next_ values are formed below and copied into the flops on each edge
  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] next_phase;
  reg next_start;
  reg next_test_lamp;
  reg [6:0] next_lamps;
  reg next_normal;
  reg next_param;
  reg next_ext;
  reg next_unusable;

  wire in_test = (mode_select == `STL_MODE_TEST);
  wire phase_last = (test_phase == `STL_PH_MEM2);
  wire [2:0] phase_step = test_phase + 3'h1;

  // positions outside the four named ones are reported, never acted on
  function mode_usable;
    input [3:0] sel;
    begin
      case (sel)
        `STL_MODE_NORMAL: begin
          mode_usable = 1'h1;
        end
        `STL_MODE_PARAM: begin
          mode_usable = 1'h1;
        end
        `STL_MODE_TEST: begin
          mode_usable = 1'h1;
        end
        `STL_MODE_EXT: begin
          mode_usable = 1'h1;
        end
        default: begin
          mode_usable = 1'h0;
        end
      endcase
    end
  endfunction

  always @* begin
    next_normal = (mode_select == `STL_MODE_NORMAL);
    next_param = (mode_select == `STL_MODE_PARAM);
    next_ext = (mode_select == `STL_MODE_EXT);
    next_unusable = !mode_usable(mode_select);
  end

  // registered so a selector caught mid-turn shows up as one clean change
  always @(posedge mclk) begin
    if (srst) begin
      mode_normal <= 1'h0;
      mode_param <= 1'h0;
      mode_ext <= 1'h0;
      mode_unusable <= 1'h0;
    end else begin
      mode_normal <= next_normal;
      mode_param <= next_param;
      mode_ext <= next_ext;
      mode_unusable <= next_unusable;
    end
  end

  always @* begin
    next_state = state;
    next_phase = test_phase;
    next_start = 1'h0;
    next_test_lamp = 1'h0;
    next_lamps = station_number_lamps;
    if (!in_test) begin
      // leaving test mode drops any held error so the next entry starts clean
      next_state = ST_IDLE;
      next_phase = `STL_PH_CPU;
      next_lamps = 7'h00;
    end else begin
      next_test_lamp = 1'h1;
      case (state)
        ST_IDLE: begin
          next_state = ST_RUN;
          next_phase = `STL_PH_CPU;
        end
        ST_RUN: begin
          next_start = 1'h1;
          next_lamps = run_code(test_phase);
          next_state = ST_WAIT;
        end
        ST_WAIT: begin
          // a done in the cycle of the start pulse is taken as well
          if (test_done && !test_pass) begin
            next_lamps = err_code(test_phase);
            next_state = ST_ERR;
          end else if (test_done) begin
            next_state = ST_RUN;
            if (phase_last) begin
              next_phase = `STL_PH_CPU;
            end else begin
              next_phase = phase_step;
            end
          end
        end
        ST_ERR: begin
          // no retry from here: a retry could pass and hide an intermittent fault
          next_state = ST_ERR;
        end
        default: begin
          // unreachable with four codes; kept as a safe way back
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // every diagnostic output is a flop, so the lamps never glitch
  always @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      test_phase <= `STL_PH_CPU;
      test_start <= 1'h0;
      test_lamp <= 1'h0;
      station_number_lamps <= 7'h00;
    end else begin
      state <= next_state;
      test_phase <= next_phase;
      test_start <= next_start;
      test_lamp <= next_test_lamp;
      station_number_lamps <= next_lamps;
    end
  end

  // the fault lamp follows start requests only in the two service modes
  stl_fault_lamp u_fault (
    .mclk(mclk),
    .srst(srst),
    .normal_mode(mode_normal | mode_ext),
    .exchange_start_req(exchange_start_req),
    .no_active_slave(no_active_slave),
    .duplicate_address(duplicate_address),
    .fault_lamp(fault_lamp)
  );
endmodule
`default_nettype wire

/* File: tb/stl_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module stl_sequencer_bench;
  localparam [34:0] RC = {7'h0D, 7'h0B, 7'h07, 7'h05, 7'h03};
  localparam [34:0] EC = {7'h4E, 7'h4E, 7'h46, 7'h44, 7'h42};
  localparam [23:0] FT = {6'h00, 6'h07, 6'h39, 6'h02};
  logic mclk = 0, srst = 1, test_done = 0, test_pass = 0, exchange_start_req = 0;
  logic no_active_slave = 0, duplicate_address = 0, test_start, test_lamp, fault_lamp;
  logic mode_normal, mode_param, mode_ext, mode_unusable;
  logic [3:0] mode_select = 4'h0;
  logic [2:0] test_phase;
  logic [6:0] station_number_lamps;
  int bad_count = 0, compares = 0;
  stl_sequencer i_dut (
    .mclk(mclk),
    .srst(srst),
    .mode_select(mode_select),
    .test_done(test_done),
    .test_pass(test_pass),
    .exchange_start_req(exchange_start_req),
    .no_active_slave(no_active_slave),
    .duplicate_address(duplicate_address),
    .test_phase(test_phase),
    .test_start(test_start),
    .test_lamp(test_lamp),
    .station_number_lamps(station_number_lamps),
    .mode_normal(mode_normal),
    .mode_param(mode_param),
    .mode_ext(mode_ext),
    .mode_unusable(mode_unusable),
    .fault_lamp(fault_lamp)
  );
  initial forever #50 mclk = ~mclk;
  task chk(input string n, input logic [6:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_seq;
    // fail at each phase; k of 9 fails the last phase after a full wrap
    for (int k = 0; k < 10; k += (k == 3) ? 6 : 1) begin
      mode_select = 4'h0;
      repeat (3) @(negedge mclk);
      mode_select = 4'h2;
      for (int i = 0; i <= k; i++) begin
        repeat (9) if (test_start !== 1'b1) @(negedge mclk);
        chk("run", RC[i % 5 * 7 +: 7], station_number_lamps);
        chk("phase", i % 5, test_phase);
        @(negedge mclk);
        {test_done, test_pass} = {1'b1, i < k};
        @(negedge mclk);
        test_done = 0;
      end
      repeat (4) @(negedge mclk);
      chk("err", EC[k % 5 * 7 +: 7], station_number_lamps);
      chk("err lamp", 1, test_lamp);
    end
    $display("t_seq end");
  endtask
  task t_fault;
    for (int c = 0; c < 4; c++) begin
      {mode_select, no_active_slave, duplicate_address} = FT[c * 6 +: 6];
      repeat (3) @(negedge mclk);
      exchange_start_req = 1;
      repeat (2) @(negedge mclk);
      chk("fault", c < 2, fault_lamp);
      exchange_start_req = 0;
      repeat (2) @(negedge mclk);
    end
    $display("t_fault end");
  endtask
  task t_mode;
    for (int m = 0; m < 16; m++) begin
      mode_select = m[3:0];
      repeat (2) @(negedge mclk);
      chk("normal", m == 0, mode_normal);
      chk("param", m == 1, mode_param);
      chk("ext", m == 14, mode_ext);
      chk("unusable", m > 2 && m != 14, mode_unusable);
      chk("test lamp", m == 2, test_lamp);
    end
    $display("t_mode end");
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    srst = 0;
    t_seq;
    t_fault;
    t_mode;
    summarize;
  end
  initial begin
    #200us bad_count++;
    summarize;
  end
endmodule
`default_nettype wire

/* File: tb/stl_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module stl_chk (
  input wire logic mclk, srst, test_done, test_pass, test_start, test_lamp, fault_lamp,
    exchange_start_req, no_active_slave, duplicate_address, mode_normal, mode_ext,
    mode_unusable,
  input wire logic [3:0] mode_select,
  input wire logic [6:0] station_number_lamps
);
  wire [6:0] l = station_number_lamps;
  // waiting on a passing or failing phase; the latency bound tolerates one state of lag
  wire w = test_done && test_lamp && !test_start && !l[6];
  wire r = exchange_start_req;
  wire m = mode_normal || mode_ext;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  go_test_a: assert property ($rose(mode_select == 4'h2) |-> ##[2:3] test_start)
    else $error("go");
  next_phase_a: assert property (w && test_pass |-> ##[1:2] test_start)
    else $error("step");
  error_hold_a: assert property (w && !test_pass |-> ##[1:3] l[6] && !l[0])
    else $error("err");
  run_code_a: assert property (test_start |-> !l[6] && l[0]) else $error("run");
  lamp_lit_a: assert property (test_start || l[6] |-> test_lamp) else $error("lamp");
  no_slave_a: assert property ($rose(r) && m && no_active_slave |-> ##[1:2] fault_lamp)
    else $error("slave");
  dup_addr_a: assert property ($rose(r) && m && duplicate_address |-> ##[1:2] fault_lamp)
    else $error("dup");
  lamp_dark_a: assert property (!r ##1 !r |=> !fault_lamp) else $error("dark");
  sel_unusable_a: assert property (mode_select > 4'h2 && mode_select != 4'hE |=> mode_unusable)
    else $error("sel");
  cover property (w && test_pass);
  cover property (w && !test_pass);
  cover property (fault_lamp);
  cover property (mode_unusable);
endmodule
bind stl_sequencer stl_chk i_chk (
  .mclk(mclk),
  .srst(srst),
  .test_done(test_done),
  .test_pass(test_pass),
  .test_start(test_start),
  .test_lamp(test_lamp),
  .fault_lamp(fault_lamp),
  .exchange_start_req(exchange_start_req),
  .no_active_slave(no_active_slave),
  .duplicate_address(duplicate_address),
  .mode_normal(mode_normal),
  .mode_ext(mode_ext),
  .mode_unusable(mode_unusable),
  .mode_select(mode_select),
  .station_number_lamps(station_number_lamps)
);
`default_nettype wire
